// File: hdl/ascc_map.vh
`ifndef ASCC_MAP_VH
`define ASCC_MAP_VH
// register indices (byte addresses)
`define ASCC_ADDR_CTRL1      3'h0
`define ASCC_ADDR_CTRL2      3'h1
`define ASCC_ADDR_TXDATA     3'h2
`define ASCC_ADDR_RXDATA     3'h3
`define ASCC_ADDR_STATUS     3'h4
`define ASCC_ADDR_BAUD       3'h5
// control one fields
`define ASCC_C1_LOOP         7
`define ASCC_C1_WAIT_STOP    6
`define ASCC_C1_RECEIVER_SOURCE         5
`define ASCC_C1_LEN9         4
`define ASCC_C1_ROUSE        3
`define ASCC_C1_IDLE_ORIGIN  2
`define ASCC_C1_PAR_ON       1
`define ASCC_C1_PAR_ODD      0
// control two fields
`define ASCC_C2_TX_EN        3
`define ASCC_C2_RX_EN        2
`define ASCC_C2_STANDBY      1
`define ASCC_C2_BREAK        0
// reset values
`define ASCC_RST_CTRL1       8'h00
`define ASCC_RST_CTRL2       8'h00
`define ASCC_RST_BAUD        8'h0A
// timing
`define ASCC_OVERSAMPLE      5'h10
`define ASCC_IDLE_BITS8      4'hA
`define ASCC_IDLE_BITS9      4'hB
`endif

// File: hdl/ascc_top.v
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "ascc_map.vh"
module ascc_top (
    input  wire       clk_i,
    input  wire       reset_n_i,
    input  wire [2:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output reg  [7:0] rdata_o,
    input  wire       cpu_wait_i,
    input  wire       serial_in_pin_i,
    output reg        serial_out_pin_o,
    output reg        serial_out_pin_oe_o,
    output reg        rx_parity_err_o
);
    localparam TX_IDLE  = 2'h0;
    localparam TX_DATA  = 2'h1;
    localparam TX_BREAK = 2'h2;
    localparam RX_IDLE  = 1'h0;
    localparam RX_SHIFT = 1'h1;

    reg  [7:0]  ctrl1_ff;
    reg  [7:0]  ctrl2_ff;
    reg  [7:0]  baud_ff;
    reg  [7:0]  tx_buf_ff;
    reg         tx_buf_full_ff;
    reg  [7:0]  rx_buf_ff;
    reg         rx_full_ff;
    reg         rx_bit8_ff;
    reg         tx_bit8_ff;
    reg  [7:0]  baud_cnt_ff;
    reg  [3:0]  os_cnt_ff;
    reg  [1:0]  tx_st_ff;
    reg  [9:0]  tx_sh_ff;
    reg  [3:0]  tx_bits_ff;
    reg         tx_line_ff;
    reg         brk_pend_ff;
    reg         rx_st_ff;
    reg  [3:0]  rx_os_ff;
    reg  [3:0]  rx_bits_ff;
    reg  [8:0]  rx_sh_ff;
    reg  [3:0]  idle_cnt_ff;
    reg         idle_arm_ff;
    reg         pin_s1_ff;
    reg         pin_s2_ff;
    // bit7 of the last control two write, kept for the ninth transmit bit
    reg         ninth_wr_ff;

    wire loop_sel = ctrl1_ff[`ASCC_C1_LOOP];
    wire receiver_source     = ctrl1_ff[`ASCC_C1_RECEIVER_SOURCE];
    wire len9     = ctrl1_ff[`ASCC_C1_LEN9];
    wire par_on   = ctrl1_ff[`ASCC_C1_PAR_ON];
    wire par_odd  = ctrl1_ff[`ASCC_C1_PAR_ODD];
    wire rouse    = ctrl1_ff[`ASCC_C1_ROUSE];
    wire idle_org = ctrl1_ff[`ASCC_C1_IDLE_ORIGIN];
    wire standby  = ctrl2_ff[`ASCC_C2_STANDBY];
    wire brk_bit  = ctrl2_ff[`ASCC_C2_BREAK];
    wire tx_en    = ctrl2_ff[`ASCC_C2_TX_EN];
    wire rx_en    = ctrl2_ff[`ASCC_C2_RX_EN];

    // baud and bit timing frozen while cpu waits and freeze is selected
    wire run      = ~(cpu_wait_i & ctrl1_ff[`ASCC_C1_WAIT_STOP]);
    wire os_tick  = run & (baud_cnt_ff == 8'h00);
    wire bit_tick = os_tick & (os_cnt_ff == 4'hF);
    wire [3:0] char_bits = len9 ? `ASCC_IDLE_BITS9 : `ASCC_IDLE_BITS8;

    // a queued or held break takes the line ahead of buffered data
    wire brk_req   = brk_pend_ff | brk_bit;
    wire tx_idle   = (tx_st_ff == TX_IDLE);
    // buffer moves to the shifter only on the tick that starts a frame,
    // so the full flag must not drop on any earlier idle cycle
    wire tx_load   = tx_idle & bit_tick & tx_en & tx_buf_full_ff & ~brk_req;

    // internal loop keeps the pin at the mark level
    wire pin_quiet = loop_sel & ~receiver_source;

    // transmit parity over the non-parity data bits
    wire par_seed = par_odd;
    wire tx_par8  = ^tx_buf_ff[6:0] ^ par_seed;
    wire tx_par9  = ^tx_buf_ff ^ par_seed;
    wire [7:0] tx_byte = (par_on & ~len9) ?
                         {tx_par8, tx_buf_ff[6:0]} : tx_buf_ff;
    wire tx_ninth = (par_on & len9) ? tx_par9 : tx_bit8_ff;

    // receiver source selection
    wire rx_line = loop_sel ? tx_line_ff
                            : pin_s2_ff;

    wire [8:0] rx_word = len9 ? rx_sh_ff : {1'b0, rx_sh_ff[8:1]};
    wire rx_msb   = len9 ? rx_word[8] : rx_word[7];
    wire rx_par_bad = par_on & ((^rx_word) != par_odd);
    wire rx_done  = (rx_st_ff == RX_SHIFT) & os_tick & (rx_os_ff == 4'hF)
                    & (rx_bits_ff == char_bits - 4'h1);
    // only data bits enter the shifter; start and stop stay out of it
    wire rx_data_bit = (rx_bits_ff != 4'h0)
                       & (rx_bits_ff != char_bits - 4'h1);
    wire idle_hit = idle_arm_ff & bit_tick & rx_line
                    & (idle_cnt_ff == char_bits - 4'h1);
    wire wake_evt = rouse ? (rx_done & rx_msb)
                          : idle_hit;

    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            pin_s1_ff <= 1'b1;
            pin_s2_ff <= 1'b1;
        end else begin
            pin_s1_ff <= serial_in_pin_i;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // register bus
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            ctrl1_ff       <= `ASCC_RST_CTRL1;
            ctrl2_ff       <= `ASCC_RST_CTRL2;
            baud_ff        <= `ASCC_RST_BAUD;
            tx_buf_ff      <= 8'h00;
            tx_bit8_ff     <= 1'b0;
            tx_buf_full_ff <= 1'b0;
            ninth_wr_ff    <= 1'b0;
            rdata_o        <= 8'h00;
        end else begin
            rdata_o <= 8'h00;
            if (wr_i && addr_i == `ASCC_ADDR_CTRL1)
                ctrl1_ff <= wdata_i;
            if (wr_i && addr_i == `ASCC_ADDR_CTRL2)
                ninth_wr_ff <= wdata_i[7];
            // a software write wins over a same-cycle hardware clear
            if (wr_i && addr_i == `ASCC_ADDR_CTRL2)
                ctrl2_ff <= wdata_i & 8'h0F;
            else if (wake_evt && rx_en)
                ctrl2_ff[`ASCC_C2_STANDBY] <= 1'b0;
            if (wr_i && addr_i == `ASCC_ADDR_BAUD)
                baud_ff <= wdata_i;
            if (wr_i && addr_i == `ASCC_ADDR_TXDATA) begin
                tx_buf_ff      <= wdata_i;
                tx_bit8_ff     <= ninth_wr_ff;
                tx_buf_full_ff <= 1'b1;
            end else if (tx_load) begin
                tx_buf_full_ff <= 1'b0;
            end
            if (rd_i) begin
                case (addr_i)
                    `ASCC_ADDR_CTRL1:  rdata_o <= ctrl1_ff;
                    `ASCC_ADDR_CTRL2:  rdata_o <= ctrl2_ff;
                    `ASCC_ADDR_RXDATA: rdata_o <= rx_buf_ff;
                    `ASCC_ADDR_STATUS: rdata_o <= {4'h0, rx_bit8_ff,
                                           rx_full_ff, tx_buf_full_ff,
                                           tx_st_ff != TX_IDLE};
                    `ASCC_ADDR_BAUD:   rdata_o <= baud_ff;
                    default:           rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // baud and oversample counters
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            baud_cnt_ff <= 8'h00;
            os_cnt_ff   <= 4'h0;
        end else if (run) begin
            if (baud_cnt_ff == 8'h00) begin
                baud_cnt_ff <= baud_ff;
                os_cnt_ff   <= os_cnt_ff + 4'h1;
            end else begin
                baud_cnt_ff <= baud_cnt_ff - 8'h01;
            end
        end
    end

    // transmitter
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            tx_st_ff    <= TX_IDLE;
            tx_sh_ff    <= 10'h3FF;
            tx_bits_ff  <= 4'h0;
            tx_line_ff  <= 1'b1;
            brk_pend_ff <= 1'b0;
        end else begin
            // a 0-to-1 write of the break bit queues one break
            if (wr_i && addr_i == `ASCC_ADDR_CTRL2 &&
                wdata_i[`ASCC_C2_BREAK] && !brk_bit)
                brk_pend_ff <= 1'b1;
            else if (tx_st_ff == TX_IDLE && bit_tick && tx_en)
                brk_pend_ff <= 1'b0;
            if (bit_tick) begin
                case (tx_st_ff)
                    TX_IDLE: begin
                        tx_line_ff <= 1'b1;
                        tx_bits_ff <= 4'h0;
                        if (tx_en && (brk_pend_ff || brk_bit)) begin
                            tx_st_ff   <= TX_BREAK;
                            tx_line_ff <= 1'b0;
                        end else if (tx_en && tx_buf_full_ff) begin
                            tx_st_ff   <= TX_DATA;
                            tx_line_ff <= 1'b0;
                            tx_sh_ff   <= len9 ?
                                {1'b1, tx_ninth, tx_byte} :
                                {2'h3, tx_byte};
                        end
                    end
                    TX_DATA: begin
                        tx_line_ff <= tx_sh_ff[0];
                        tx_sh_ff   <= {1'b1, tx_sh_ff[9:1]};
                        tx_bits_ff <= tx_bits_ff + 4'h1;
                        if (tx_bits_ff == char_bits - 4'h1) begin
                            tx_st_ff   <= TX_IDLE;
                            tx_line_ff <= 1'b1;
                        end
                    end
                    TX_BREAK: begin
                        tx_bits_ff <= tx_bits_ff + 4'h1;
                        if (tx_bits_ff == char_bits - 4'h1) begin
                            tx_st_ff   <= TX_IDLE;
                            tx_line_ff <= 1'b1;
                        end
                    end
                    default: tx_st_ff <= TX_IDLE;
                endcase
            end
        end
    end

    // pin drive
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            serial_out_pin_o    <= 1'b1;
            serial_out_pin_oe_o <= 1'b0;
        end else begin
            if (pin_quiet)
                serial_out_pin_o <= 1'b1;
            else
                serial_out_pin_o <= tx_line_ff;
            serial_out_pin_oe_o <= tx_en & (~loop_sel | receiver_source);
        end
    end

    // receiver
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            rx_st_ff        <= RX_IDLE;
            rx_os_ff        <= 4'h0;
            rx_bits_ff      <= 4'h0;
            rx_sh_ff        <= 9'h000;
            rx_buf_ff       <= 8'h00;
            rx_bit8_ff      <= 1'b0;
            rx_full_ff      <= 1'b0;
            rx_parity_err_o <= 1'b0;
            idle_cnt_ff     <= 4'h0;
            idle_arm_ff     <= 1'b0;
        end else begin
            if (rd_i && addr_i == `ASCC_ADDR_RXDATA)
                rx_full_ff <= 1'b0;
            // idle count origin: after start bit or after stop bit
            if (bit_tick) begin
                if (!rx_line)
                    idle_cnt_ff <= 4'h0;
                else if (idle_hit)
                    idle_arm_ff <= 1'b0;
                else
                    idle_cnt_ff <= idle_cnt_ff + 4'h1;
            end
            if (rx_en && os_tick) begin
                case (rx_st_ff)
                    RX_IDLE: begin
                        if (!rx_line) begin
                            rx_st_ff   <= RX_SHIFT;
                            rx_os_ff   <= 4'h0;
                            rx_bits_ff <= 4'h0;
                            if (!idle_org) begin
                                idle_arm_ff <= 1'b1;
                                idle_cnt_ff <= 4'h0;
                            end
                        end
                    end
                    RX_SHIFT: begin
                        rx_os_ff <= rx_os_ff + 4'h1;
                        if (rx_os_ff == 4'h7 && rx_data_bit)
                            rx_sh_ff <= {rx_line, rx_sh_ff[8:1]};
                        if (rx_os_ff == 4'hF) begin
                            rx_bits_ff <= rx_bits_ff + 4'h1;
                            if (rx_done) begin
                                rx_st_ff <= RX_IDLE;
                                if (idle_org) begin
                                    idle_arm_ff <= 1'b1;
                                    idle_cnt_ff <= 4'h0;
                                end
                                if (!standby || (rouse && rx_msb)) begin
                                    rx_buf_ff  <= rx_word[7:0];
                                    rx_bit8_ff <= rx_word[8];
                                    rx_full_ff <= 1'b1;
                                    rx_parity_err_o <= rx_par_bad;
                                end
                            end
                        end
                    end
                    default: rx_st_ff <= RX_IDLE;
                endcase
            end
        end
    end
endmodule

// File: tb/ascc_far_end.sv
`timescale 1ns/10ps
module ascc_far_end #(
    parameter BIT_CLKS = 16
) (
    input  wire clk_i,
    output reg  line_o
);
    // the line idles at the mark level between characters
    initial line_o = 1'b1;

    task send(input [8:0] d, input integer nb);
        integer i;
        begin
            @(posedge clk_i);
            line_o <= 1'b0;
            repeat (BIT_CLKS) @(posedge clk_i);
            for (i = 0; i < nb; i = i + 1) begin
                line_o <= d[i];
                repeat (BIT_CLKS) @(posedge clk_i);
            end
            line_o <= 1'b1;
            repeat (BIT_CLKS) @(posedge clk_i);
            // one idle bit time so the receiver closes the stop bit
            repeat (BIT_CLKS) @(posedge clk_i);
        end
    endtask
endmodule

// File: tb/ascc_top_asserts.sv
`timescale 1ns/10ps
module ascc_chk (
    input wire       clk_i,
    input wire       reset_n_i,
    input wire [2:0] addr_i,
    input wire [7:0] wdata_i,
    input wire       wr_i,
    input wire       rd_i,
    input wire [7:0] rdata_o,
    input wire       cpu_wait_i,
    input wire       serial_in_pin_i,
    input wire       serial_out_pin_o,
    input wire       serial_out_pin_oe_o,
    input wire       rx_parity_err_o
);
    reg  [7:0] c1_ff;
    reg        tx_on_ff;
    wire       lb = c1_ff[7] && !c1_ff[5];
    wire       sw = c1_ff[7] && c1_ff[5] && tx_on_ff;

    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            c1_ff    <= 8'h00;
            tx_on_ff <= 1'b0;
        end else begin
            if (wr_i && addr_i == 3'h0)
                c1_ff <= wdata_i;
            if (wr_i && addr_i == 3'h1)
                tx_on_ff <= wdata_i[3];
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_lb; lb ##1 lb; endsequence
    sequence s_sw; sw ##1 sw; endsequence

    property p_rd_idle; !rd_i |=> rdata_o == 8'h00; endproperty
    property p_c1_back;
        rd_i && addr_i == 3'h0 |=> rdata_o == $past(c1_ff);
    endproperty
    property p_c2_hi; rd_i && addr_i == 3'h1 |=> rdata_o[7:4] == 4'h0;
    endproperty
    property p_unmap; rd_i && addr_i > 3'h5 |=> rdata_o == 8'h00;
    endproperty
    property p_lb_oe; s_lb |-> !serial_out_pin_oe_o; endproperty
    property p_lb_pin; s_lb |-> serial_out_pin_o; endproperty
    property p_sw_oe; s_sw |-> serial_out_pin_oe_o; endproperty
    property p_freeze;
        (c1_ff[6] && cpu_wait_i) [*2] |-> $stable(serial_out_pin_o);
    endproperty

    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not cleared");
    a_c1_back: assert property (p_c1_back)
        else $error("control one readback wrong");
    a_c2_hi: assert property (p_c2_hi)
        else $error("control two upper bits not zero");
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
    a_lb_oe: assert property (p_lb_oe)
        else $error("pin driven in internal loop");
    a_lb_pin: assert property (p_lb_pin)
        else $error("pin not idle in internal loop");
    a_sw_oe: assert property (p_sw_oe)
        else $error("pin not driven in single wire");
    a_freeze: assert property (p_freeze)
        else $error("line moved while frozen");
endmodule

bind ascc_top ascc_chk chk_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .cpu_wait_i(cpu_wait_i), .serial_in_pin_i(serial_in_pin_i),
    .serial_out_pin_o(serial_out_pin_o),
    .serial_out_pin_oe_o(serial_out_pin_oe_o),
    .rx_parity_err_o(rx_parity_err_o)
);

// File: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    reg        clk_i;
    reg        reset_n_i;
    reg  [2:0] addr_i;
    reg  [7:0] wdata_i;
    reg        wr_i;
    reg        rd_i;
    reg        cpu_wait_i;
    wire       rx_line;
    wire [7:0] rdata_o;
    wire       tx_pin;
    wire       tx_oe;
    wire       perr;
    integer    mismatches;
    integer    check_count;

    ascc_top dut_u (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .cpu_wait_i(cpu_wait_i), .serial_in_pin_i(rx_line),
        .serial_out_pin_o(tx_pin), .serial_out_pin_oe_o(tx_oe),
        .rx_parity_err_o(perr)
    );
    ascc_far_end far_u (.clk_i(clk_i), .line_o(rx_line));

    task chk(input string nm, input [10:0] got, input [10:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("[ERR] %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        begin
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
            @(posedge clk_i);
            wr_i <= 1'b0;
            #1;
        end
    endtask
    task rd(input [2:0] a, output [7:0] d);
        begin
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge clk_i);
            rd_i <= 1'b0;
            #1;
            d = rdata_o;
        end
    endtask
    // waits for a start bit, then samples each bit at its middle
    task cap(input integer nb, output [10:0] v);
        integer i;
        begin
            v = 11'h000;
            i = 0;
            while (tx_pin !== 1'b0 && i < 2000) begin
                @(posedge clk_i) #1;
                i = i + 1;
            end
            repeat (8) @(posedge clk_i);
            for (i = 0; i <= nb + 1; i = i + 1) begin
                v[i] = tx_pin;
                repeat (16) @(posedge clk_i);
            end
        end
    endtask
    task t_regs;
        reg [7:0] d;
        begin
            rd(3'h0, d); chk("c1", d, 8'h00);
            rd(3'h1, d); chk("c2", d, 8'h00);
            rd(3'h5, d); chk("baud", d, 8'h0A);
            wr(3'h0, 8'hA5);
            rd(3'h0, d); chk("c1", d, 8'hA5);
            wr(3'h1, 8'hFC);
            rd(3'h1, d); chk("c2", d, 8'h0C);
            rd(3'h6, d); chk("unmap", d, 8'h00);
            wr(3'h5, 8'h00);
        end
    endtask
    task t_tx;
        integer k, nb;
        reg [7:0] c1;
        reg [8:0] e;
        reg [10:0] v;
        reg [47:0] tbl;
        begin
            tbl = 48'h20_02_03_12_13_10;
            for (k = 0; k < 6; k = k + 1) begin
                c1 = tbl[47 - 8 * k -: 8];
                nb = c1[4] ? 9 : 8;
                e = {c1[4], 8'h5A + k[7:0]};
                if (c1[1]) begin
                    e[nb - 1] = 1'b0;
                    e[nb - 1] = ^e ^ c1[0];
                end
                wr(3'h0, c1);
                wr(3'h1, 8'h88);
                wr(3'h2, 8'h5A + k[7:0]);
                cap(nb, v);
                chk("tx", v, (11'h001 << (nb + 1)) | ({2'h0, e} << 1));
            end
        end
    endtask
    task t_brk;
        integer k, n;
        begin
            for (k = 0; k < 2; k = k + 1) begin
                wr(3'h0, k ? 8'h10 : 8'h00);
                wr(3'h1, 8'h09);
                wr(3'h1, 8'h08);
                n = 0;
                while (tx_pin !== 1'b0 && n < 400) begin
                    @(posedge clk_i) #1;
                    n = n + 1;
                end
                n = 0;
                while (tx_pin === 1'b0 && n < 400) begin
                    @(posedge clk_i) #1;
                    n = n + 1;
                end
                chk("brk", n, k ? 11'h0B0 : 11'h0A0);
            end
        end
    endtask
    task t_rx;
        reg [7:0] d;
        begin
            wr(3'h0, 8'h02);
            wr(3'h1, 8'h04);
            far_u.send(9'h0C3, 8);
            rd(3'h3, d); chk("rx", d, 8'hC3);
            chk("perr", perr, 1'b0);
            far_u.send(9'h043, 8);
            chk("perr", perr, 1'b1);
        end
    endtask
    task t_loop;
        integer k;
        reg [7:0] d;
        begin
            for (k = 0; k < 2; k = k + 1) begin
                wr(3'h0, k ? 8'hA0 : 8'h80);
                wr(3'h1, 8'h0C);
                fork
                    far_u.send(9'h0F0, 8);
                    wr(3'h2, 8'h5A);
                join
                repeat (200) @(posedge clk_i);
                chk("oe", tx_oe, k[0]);
                rd(3'h3, d); chk("loop", d, 8'h5A);
            end
        end
    endtask
    task t_wake;
        reg [7:0] d;
        begin
            wr(3'h0, 8'h08);
            wr(3'h1, 8'h06);
            far_u.send(9'h012, 8);
            rd(3'h1, d); chk("stby", d[1], 1'b1);
            far_u.send(9'h093, 8);
            rd(3'h1, d); chk("stby", d[1], 1'b0);
            wr(3'h0, 8'h04);
            wr(3'h1, 8'h06);
            far_u.send(9'h012, 8);
            repeat (220) @(posedge clk_i);
            rd(3'h1, d); chk("idle", d[1], 1'b0);
        end
    endtask
    task t_wait;
        reg [7:0] d;
        begin
            wr(3'h0, 8'h40);
            wr(3'h1, 8'h09);
            wr(3'h1, 8'h08);
            repeat (30) @(posedge clk_i);
            cpu_wait_i <= 1'b1;
            repeat (60) @(posedge clk_i);
            cpu_wait_i <= 1'b0;
            repeat (300) @(posedge clk_i);
            rd(3'h4, d); chk("busy", d[0], 1'b0);
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", check_count, mismatches);
            if (mismatches == 0 && check_count > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        mismatches = 0;
        check_count = 0;
        reset_n_i = 1'b0;
        addr_i = 3'h0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        cpu_wait_i = 1'b0;
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i) #1;
        t_regs; $display("regs done");
        t_tx; $display("tx done");
        t_brk; $display("break done");
        t_rx; $display("rx done");
        t_loop; $display("loop done");
        t_wake; $display("wake done");
        t_wait; $display("wait done");
        wrap_up;
    end
    initial begin
        #1000000;
        mismatches = mismatches + 1;
        wrap_up;
    end
endmodule
